// file: hw/sesum_params.svh
// Register offsets, field positions, reset values and codes of the status summary block
`ifndef SESUM_PARAMS_SVH
`define SESUM_PARAMS_SVH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SESUM_OFF_STB      12'h000
`define SESUM_OFF_SRE      12'h004
`define SESUM_OFF_CMD      12'h008
`define SESUM_OFF_PCHAR    12'h00C
`define SESUM_OFF_PSTAT    12'h010
`define SESUM_OFF_QSTAT    12'h014
`define SESUM_OFF_COND0    12'h020
`define SESUM_OFF_EVT0     12'h040
`define SESUM_OFF_ENA0     12'h060
`define SESUM_SET_STRIDE   12'h004
// ---------------------------------------------------------------
// Status byte bit positions
// ---------------------------------------------------------------
`define SESUM_STB_MEAS     0
`define SESUM_STB_ERR      2
`define SESUM_STB_QUES     3
`define SESUM_STB_MSG      4
`define SESUM_STB_STD      5
`define SESUM_STB_RQS      6
`define SESUM_STB_OPER     7
// ---------------------------------------------------------------
// Command codes written to the command register
// ---------------------------------------------------------------
`define SESUM_CMD_CLS      8'h01
`define SESUM_CMD_STPRES   8'h02
`define SESUM_CMD_QCLR     8'h03
`define SESUM_CMD_ECLR     8'h04
`define SESUM_CMD_SYSPRES  8'h05
`define SESUM_CMD_RST      8'h06
`define SESUM_CMD_POLL     8'h07
`define SESUM_CMD_PSTART   8'h10
`define SESUM_CMD_PEND     8'h20
// ---------------------------------------------------------------
// Reset values and queue depths
// ---------------------------------------------------------------
`define SESUM_RST16        16'h0000
`define SESUM_RST8         8'h00
`define SESUM_QDEPTH       8
`define SESUM_ERR_PARSE    8'hF1
`endif

// file: hw/sesum_pkg.sv
// Types shared by the status summary block
package sesum_pkg;
  typedef enum logic [1:0] {
    SESUM_P_RADIX = 2'b00,
    SESUM_P_DIGIT = 2'b01,
    SESUM_P_BAD   = 2'b10
  } sesum_pstate_t;

  typedef enum logic [1:0] {
    SESUM_RX_DEC = 2'b00,
    SESUM_RX_BIN = 2'b01,
    SESUM_RX_HEX = 2'b10,
    SESUM_RX_OCT = 2'b11
  } sesum_radix_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } sesum_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sesum_apb_rsp_t;
endpackage : sesum_pkg

// file: hw/sesum_top.sv
// Status summary block: register sets, queues, status byte and parameter parser
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "sesum_params.svh"
module sesum_top #(
  parameter int NSETS  = 4,
  parameter int QDEPTH = `SESUM_QDEPTH
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    srst_i,
  input  wire sesum_pkg::sesum_apb_req_t apb_req_i,
  output sesum_pkg::sesum_apb_rsp_t    apb_rsp_o,
  input  wire logic [NSETS*16-1:0]     cond_i,
  input  wire logic                    oq_push_i,
  input  wire logic                    oq_pop_i,
  input  wire logic                    eq_push_i,
  input  wire logic                    eq_pop_i,
  output logic [7:0]                   status_byte_o,
  output logic                         srq_o
);
  import sesum_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Set index 0 standard, 1 operation, 2 measurement, 3 questionable
  localparam int STD  = 0;
  localparam int OPER = 1;
  localparam int MEAS = 2;
  localparam int QUES = 3;

  // Digit value of a character for a radix, bit 4 flags invalid
  function automatic logic [4:0] digit_val(input logic [7:0] c, input sesum_radix_t r);
    logic [7:0] u;
    u = c & 8'hDF;
    digit_val = 5'h10;
    if (c >= 8'h30 && c <= 8'h39) digit_val = {1'b0, c[3:0]};
    else if (u >= 8'h41 && u <= 8'h46) digit_val = 5'(u - 8'h37);
    case (r)
      SESUM_RX_BIN: if (digit_val > 5'h01) digit_val = 5'h10;
      SESUM_RX_OCT: if (digit_val > 5'h07) digit_val = 5'h10;
      SESUM_RX_DEC: if (digit_val > 5'h09) digit_val = 5'h10;
      default: ;
    endcase
  endfunction : digit_val

  // Radix multiply-accumulate, kept to 16 bits
  function automatic logic [15:0] accum(input logic [15:0] a, input logic [3:0] d, input sesum_radix_t r);
    case (r)
      SESUM_RX_BIN: accum = {a[14:0], 1'b0} + {12'h000, d};
      SESUM_RX_OCT: accum = {a[12:0], 3'b000} + {12'h000, d};
      SESUM_RX_HEX: accum = {a[11:0], 4'h0} + {12'h000, d};
      default:      accum = {a[12:0], 3'b000} + {a[14:0], 1'b0} + {12'h000, d};
    endcase
  endfunction : accum

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NSETS-1:0][15:0] cond;
    logic [NSETS-1:0][15:0] evt;
    logic [NSETS-1:0][15:0] ena;
    logic [7:0]             sre;
    logic [3:0]             oq_cnt;
    logic [3:0]             eq_cnt;
    logic                   rqs;
    logic                   mss_prev;
    sesum_pstate_t          pst;
    sesum_radix_t           prx;
    logic [15:0]            pacc;
    logic [3:0]             ptgt;
    logic                   perr;
    logic [7:0]             stb;
    logic                   srq;
    sesum_apb_rsp_t         rsp;
  } sesum_state_t;

  sesum_state_t st_q;
  sesum_state_t st_d;

  logic        wr_acc;
  logic        rd_acc;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [NSETS-1:0] set_sum;
  logic [7:0]  sum_bits;
  logic        mss;
  logic        eq_clear;
  logic        eq_add;
  logic [4:0]  dv;
  logic [3:0]  sidx;

  assign wr_acc = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
  assign rd_acc = apb_req_i.psel & ~apb_req_i.pwrite;
  assign addr   = apb_req_i.paddr;
  assign wdata  = apb_req_i.pwdata;
  assign dv     = digit_val(wdata[7:0], st_q.prx);
  assign sidx   = 4'(addr[4:2]);

  // Summary of each set from event and enable
  always_comb begin
    for (int i = 0; i < NSETS; i++) begin
      set_sum[i] = |(st_q.evt[i] & st_q.ena[i]);
    end
  end

  // Status byte summary bits follow sources directly
  always_comb begin
    sum_bits                   = `SESUM_RST8;
    sum_bits[`SESUM_STB_MEAS]  = set_sum[MEAS];
    sum_bits[`SESUM_STB_ERR]   = st_q.eq_cnt != 4'h0;
    sum_bits[`SESUM_STB_QUES]  = set_sum[QUES];
    sum_bits[`SESUM_STB_MSG]   = st_q.oq_cnt != 4'h0;
    sum_bits[`SESUM_STB_STD]   = set_sum[STD];
    sum_bits[`SESUM_STB_OPER]  = set_sum[OPER];
    mss                        = |(sum_bits & st_q.sre);
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    st_d             = st_q;
    eq_clear         = 1'b0;
    eq_add           = 1'b0;
    st_d.rsp.pready  = 1'b1;
    st_d.rsp.pslverr = 1'b0;
    st_d.rsp.prdata  = 32'h0000_0000;
    st_d.cond        = cond_i;

    // Latch events on rising condition edges
    for (int i = 0; i < NSETS; i++) begin
      st_d.evt[i] = st_q.evt[i] | (cond_i[i*16 +: 16] & ~st_q.cond[i]);
    end

    // Register writes; only the request enable, the enables, the command register and the character register are writable
    if (wr_acc) begin
      if (addr == `SESUM_OFF_SRE) begin
        st_d.sre = wdata[7:0];
      end else if (addr >= `SESUM_OFF_ENA0 && addr < `SESUM_OFF_ENA0 + 12'(NSETS*4)) begin
        st_d.ena[sidx] = wdata[15:0];
      end else if (addr == `SESUM_OFF_CMD) begin
        case (wdata[7:0])
          `SESUM_CMD_CLS: begin
            // Clear-status empties events, but an edge in the same cycle still sets its bit
            for (int i = 0; i < NSETS; i++) st_d.evt[i] = cond_i[i*16 +: 16] & ~st_q.cond[i];
            eq_clear = 1'b1;
          end
          `SESUM_CMD_STPRES: begin
            st_d.ena[OPER] = `SESUM_RST16;
            st_d.ena[MEAS] = `SESUM_RST16;
            st_d.ena[QUES] = `SESUM_RST16;
          end
          `SESUM_CMD_QCLR, `SESUM_CMD_ECLR: eq_clear = 1'b1;
          `SESUM_CMD_SYSPRES, `SESUM_CMD_RST: ;
          `SESUM_CMD_POLL: st_d.rqs = 1'b0;
          `SESUM_CMD_PSTART: begin
            st_d.pst  = SESUM_P_RADIX;
            st_d.pacc = `SESUM_RST16;
            st_d.prx  = SESUM_RX_DEC;
            st_d.ptgt = wdata[11:8];
            st_d.perr = 1'b0;
          end
          `SESUM_CMD_PEND: begin
            if (st_q.pst == SESUM_P_BAD) begin
              eq_add    = 1'b1;
              st_d.perr = 1'b1;
            end else if (st_q.ptgt == 4'hF) begin
              st_d.sre = st_q.pacc[7:0];
            end else if (st_q.ptgt < 4'(NSETS)) begin
              st_d.ena[st_q.ptgt[1:0]] = st_q.pacc;
            end
            st_d.pst = SESUM_P_RADIX;
          end
          default: ;
        endcase
      end else if (addr == `SESUM_OFF_PCHAR) begin
        // Character stream of a programming value
        case (st_q.pst)
          SESUM_P_RADIX: begin
            if (wdata[7:0] == 8'h23) begin
              st_d.pst = SESUM_P_RADIX;
              st_d.prx = SESUM_RX_HEX;                      // header pending marker
            end else if (st_q.prx == SESUM_RX_HEX && st_q.pacc == `SESUM_RST16 &&
                         (wdata[7:0] & 8'hDF) == 8'h42) begin
              st_d.prx = SESUM_RX_BIN; st_d.pst = SESUM_P_DIGIT;
            end else if (st_q.prx == SESUM_RX_HEX && (wdata[7:0] & 8'hDF) == 8'h48) begin
              st_d.pst = SESUM_P_DIGIT;
            end else if (st_q.prx == SESUM_RX_HEX && (wdata[7:0] & 8'hDF) == 8'h51) begin
              st_d.prx = SESUM_RX_OCT; st_d.pst = SESUM_P_DIGIT;
            end else if (st_q.prx == SESUM_RX_DEC && !dv[4]) begin
              st_d.pacc = accum(st_q.pacc, dv[3:0], SESUM_RX_DEC);
              st_d.pst  = SESUM_P_DIGIT;
            end else begin
              st_d.pst = SESUM_P_BAD;
            end
          end
          SESUM_P_DIGIT: begin
            if (dv[4]) st_d.pst = SESUM_P_BAD;
            else st_d.pacc = accum(st_q.pacc, dv[3:0], st_q.prx);
          end
          SESUM_P_BAD: ;
          default: st_d.pst = SESUM_P_BAD;
        endcase
      end else begin
        // Any other write hits a read-only or unmapped word and is refused
        st_d.rsp.pslverr = 1'b1;
      end
    end

    // Register reads, answered in the access phase
    if (rd_acc) begin
      if (addr == `SESUM_OFF_STB)
        st_d.rsp.prdata = {24'h000000, sum_bits | {1'b0, mss, 6'b000000}};
      else if (addr == `SESUM_OFF_SRE)
        st_d.rsp.prdata = {24'h000000, st_q.sre};
      else if (addr == `SESUM_OFF_PSTAT)
        st_d.rsp.prdata = {st_q.perr, 13'h0000, st_q.pst, st_q.pacc};
      else if (addr == `SESUM_OFF_QSTAT)
        st_d.rsp.prdata = {16'h0000, 4'h0, st_q.eq_cnt, 4'h0, st_q.oq_cnt};
      else if (addr >= `SESUM_OFF_COND0 && addr < `SESUM_OFF_COND0 + 12'(NSETS*4))
        st_d.rsp.prdata = {16'h0000, st_q.cond[sidx]};
      else if (addr >= `SESUM_OFF_EVT0 && addr < `SESUM_OFF_EVT0 + 12'(NSETS*4)) begin
        st_d.rsp.prdata = {16'h0000, st_q.evt[sidx]};
        // Reading an event register clears it on the completing edge
        if (apb_req_i.penable) st_d.evt[sidx] = cond_i[sidx*16 +: 16] & ~st_q.cond[sidx];
      end else if (addr >= `SESUM_OFF_ENA0 && addr < `SESUM_OFF_ENA0 + 12'(NSETS*4))
        st_d.rsp.prdata = {16'h0000, st_q.ena[sidx]};
      else if (addr == `SESUM_OFF_CMD || addr == `SESUM_OFF_PCHAR)
        st_d.rsp.prdata = 32'h0000_0000;
      else
        st_d.rsp.pslverr = ~apb_req_i.penable;              // Set in setup, stands in access
    end

    // Output queue occupancy
    if (oq_push_i && !oq_pop_i && st_q.oq_cnt != 4'(QDEPTH)) st_d.oq_cnt = st_q.oq_cnt + 4'h1;
    else if (oq_pop_i && !oq_push_i && st_q.oq_cnt != 4'h0) st_d.oq_cnt = st_q.oq_cnt - 4'h1;

    // Error queue occupancy, new entries win over clear
    if (eq_clear) begin
      st_d.eq_cnt = 4'(eq_push_i | eq_add);
    end else if ((eq_push_i || eq_add) && !eq_pop_i) begin
      if (st_q.eq_cnt != 4'(QDEPTH)) st_d.eq_cnt = st_q.eq_cnt + 4'h1;
    end else if (eq_pop_i && !eq_push_i && !eq_add && st_q.eq_cnt != 4'h0) begin
      st_d.eq_cnt = st_q.eq_cnt - 4'h1;
    end

    // Request bit sets on a rising master summary, poll clears it
    if (mss && !st_q.mss_prev) st_d.rqs = 1'b1;
    st_d.mss_prev = mss;
    st_d.stb      = sum_bits | {1'b0, mss, 6'b000000};
    st_d.srq      = st_d.rqs;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q         <= '0;
      st_q.rsp.pready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign apb_rsp_o     = st_q.rsp;
  assign status_byte_o = st_q.stb;
  assign srq_o         = st_q.srq;
endmodule : sesum_top

// file: test/sesum_host.sv
// APB host model standing in for the remote test program
`timescale 1ns/1ps
module sesum_host (
  input  wire logic                      ref_clk_i,
  input  wire sesum_pkg::sesum_apb_rsp_t apb_rsp_i,
  output sesum_pkg::sesum_apb_req_t      apb_req_o
);
  import sesum_pkg::*;
  // -------------------------------------------------------------
  // Transfer task: setup, access held until pready, then release
  // -------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    apb_req_o <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge ref_clk_i);
    apb_req_o.penable <= 1'b1;
    do @(posedge ref_clk_i); while (apb_rsp_i.pready !== 1'b1);
    q = apb_rsp_i.prdata;
    e = apb_rsp_i.pslverr;
    apb_req_o.psel    <= 1'b0;
    apb_req_o.penable <= 1'b0;
    // Idle edge so the next setup never lands in the release step
    @(posedge ref_clk_i);
  endtask : xfer
  // Bus idle from time zero
  initial apb_req_o = '0;
endmodule : sesum_host

// file: test/sesum_top_sva.sv
// Port assertions of the status summary block
`timescale 1ns/1ps
`include "sesum_params.svh"
module sesum_top_sva #(
  parameter int NSETS = 4
) (
  input wire logic                      ref_clk_i,
  input wire logic                      srst_i,
  input wire sesum_pkg::sesum_apb_req_t apb_req_i,
  input wire sesum_pkg::sesum_apb_rsp_t apb_rsp_o,
  input wire logic [NSETS*16-1:0]       cond_i,
  input wire logic                      oq_push_i,
  input wire logic                      oq_pop_i,
  input wire logic                      eq_push_i,
  input wire logic                      eq_pop_i,
  input wire logic [7:0]                status_byte_o,
  input wire logic                      srq_o
);
  import sesum_pkg::*;
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  logic wr_acc, rd_acc, cmd_wr;
  logic [5:0] srcs;
  // Access-phase decode and status byte summary sources
  assign wr_acc = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
  assign rd_acc = apb_req_i.psel && apb_req_i.penable && !apb_req_i.pwrite;
  assign cmd_wr = wr_acc && apb_req_i.paddr == `SESUM_OFF_CMD;
  assign srcs   = {status_byte_o[7], status_byte_o[5:2], status_byte_o[0]};
  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  a_ready_always: assert property (apb_rsp_o.pready) else $error("pready low");
  a_spare_bit_zero: assert property (!status_byte_o[1]) else $error("bit 1 set");
  a_mss_has_source: assert property (status_byte_o[6] |-> (|srcs) || $past(|srcs))
    else $error("master summary without source");
  a_err_on_push: assert property (eq_push_i && !eq_pop_i && !apb_req_i.psel |-> ##[1:2] status_byte_o[2])
    else $error("error queue bit missing");
  a_mav_on_push: assert property (oq_push_i && !oq_pop_i && !apb_req_i.psel |-> ##[1:2] status_byte_o[4])
    else $error("output queue bit missing");
  a_reset_clears: assert property (disable iff (1'b0) srst_i |=> status_byte_o == 8'h00 && !srq_o)
    else $error("outputs not cleared by reset");
  a_cond_mirror: assert property (rd_acc && apb_req_i.paddr == `SESUM_OFF_COND0 && $stable(cond_i)
    && $past($stable(cond_i)) |-> apb_rsp_o.prdata == {16'h0000, cond_i[15:0]}) else $error("cond read wrong");
  a_ro_write_err: assert property (wr_acc && apb_req_i.paddr == `SESUM_OFF_STB |=> apb_rsp_o.pslverr)
    else $error("read-only write not refused");
  a_unmapped_err: assert property (rd_acc && apb_req_i.paddr == 12'h018 |-> apb_rsp_o.pslverr)
    else $error("unmapped read not refused");
  a_poll_clears: assert property (cmd_wr && apb_req_i.pwdata[7:0] == `SESUM_CMD_POLL |-> ##[1:2] !srq_o)
    else $error("poll left request bit set");
  a_cls_clears_err: assert property (cmd_wr && apb_req_i.pwdata[7:0] == `SESUM_CMD_CLS && !eq_push_i
    ##1 !eq_push_i |-> ##[0:1] !status_byte_o[2]) else $error("clear-status left error bit");
  // Main scenarios reached
  c_poll: cover property (cmd_wr && apb_req_i.pwdata[7:0] == `SESUM_CMD_POLL && srq_o);
  c_mss: cover property (status_byte_o[6]);
  c_err_avail: cover property (eq_push_i ##2 status_byte_o[2]);
endmodule : sesum_top_sva

// file: test/tb_status_event_summary.sv
// Self-checking bench of the status summary block
`timescale 1ns/1ps
`include "sesum_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, (g), (e)); end end
module tb_status_event_summary;
  import sesum_pkg::*;
  // -------------------------------------------------------------
  // Stimulus state and design
  // -------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [63:0] cond_q = '0;
  logic [3:0] qop_q = '0;
  sesum_apb_req_t apb_req;
  sesum_apb_rsp_t apb_rsp;
  logic [7:0] sb;
  logic srq, re;
  logic [31:0] rv;
  logic [15:0] v;
  int seed = 44, n_mismatch = 0, compares = 0;
  logic [7:0] clr [3] = '{`SESUM_CMD_CLS, `SESUM_CMD_QCLR, `SESUM_CMD_ECLR};
  string ps [5] = '{"#h2C", "#B101100", "#q54", "#Q54", "44"};
  // Clock of 100 ns period
  always #50 ref_clk_i = ~ref_clk_i;
  sesum_top #(.NSETS(4), .QDEPTH(`SESUM_QDEPTH)) dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .apb_req_i(apb_req), .apb_rsp_o(apb_rsp), .cond_i(cond_q), .oq_push_i(qop_q[0]), .oq_pop_i(qop_q[1]),
    .eq_push_i(qop_q[2]), .eq_pop_i(qop_q[3]), .status_byte_o(sb), .srq_o(srq));
  sesum_host host_u (.ref_clk_i(ref_clk_i), .apb_rsp_i(apb_rsp), .apb_req_o(apb_req));
  // -------------------------------------------------------------
  // Tasks and expectation functions
  // -------------------------------------------------------------
  function automatic logic [11:0] at(input logic [11:0] b, input int i);
    return b + 12'(4 * i);
  endfunction : at
  function automatic int pos(input int i);
    case (i)
      0: return `SESUM_STB_STD;
      1: return `SESUM_STB_OPER;
      2: return `SESUM_STB_MEAS;
      default: return `SESUM_STB_QUES;
    endcase
  endfunction : pos
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, rv, re);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    host_u.xfer(1'b0, a, 32'h0, rv, re);
    `CHK(rv, e)
  endtask : rd_chk
  task automatic cmd(input logic [7:0] c);
    wr(`SESUM_OFF_CMD, {24'h0, c});
  endtask : cmd
  task automatic settle();
    repeat (3) @(posedge ref_clk_i);
  endtask : settle
  // Queue op k: 0 out push, 1 out pop, 2 err push, 3 err pop
  task automatic tick(input int k);
    qop_q[k] <= 1'b1;
    @(posedge ref_clk_i);
    qop_q[k] <= 1'b0;
    settle();
  endtask : tick
  // Parse a parameter text into enable set t, or into the request enable when t is F
  task automatic parse(input string s, input logic [3:0] t = 4'h1);
    wr(`SESUM_OFF_CMD, {20'h0, t, `SESUM_CMD_PSTART});
    for (int k = 0; k < s.len(); k++) wr(`SESUM_OFF_PCHAR, {24'h0, s[k]});
    cmd(`SESUM_CMD_PEND);
  endtask : parse
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    end_sim();
  end
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(posedge ref_clk_i);
    `CHK({srq, sb}, 9'h000)
    rd_chk(`SESUM_OFF_QSTAT, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = (i == 3) ? 16'h8000 : 16'($random(seed));
      wr(at(`SESUM_OFF_ENA0, i), {16'h0, v});
      rd_chk(at(`SESUM_OFF_ENA0, i), {16'h0, v});
      wr(at(`SESUM_OFF_ENA0, i), 32'h0);
      rd_chk(at(`SESUM_OFF_ENA0, i), 32'h0);
      cond_q[i*16 +: 16] <= 16'($random(seed));
      settle();
      wr(at(`SESUM_OFF_COND0, i), 32'hFFFF);
      rd_chk(at(`SESUM_OFF_COND0, i), {16'h0, cond_q[i*16 +: 16]});
      rd_chk(at(`SESUM_OFF_EVT0, i), {16'h0, cond_q[i*16 +: 16]});
      rd_chk(at(`SESUM_OFF_EVT0, i), 32'h0);
    end
    v = 16'($random(seed));
    wr(`SESUM_OFF_SRE, {16'h0, v});
    rd_chk(`SESUM_OFF_SRE, {24'h0, v[7:0]});
    wr(`SESUM_OFF_SRE, 32'h0);
    wr(`SESUM_OFF_STB, 32'hFF);
    host_u.xfer(1'b0, 12'h018, 32'h0, rv, re);
    `CHK(re, 1'b1)
    cond_q <= '0;
    settle();
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(at(`SESUM_OFF_ENA0, i), 32'h1);
      cond_q[i*16] <= 1'b1;
      settle();
      `CHK(sb, 8'(1 << pos(i)))
      cond_q[i*16] <= 1'b0;
      settle();
      rd_chk(at(`SESUM_OFF_EVT0, i), 32'h1);
      settle();
      `CHK(sb, 8'h00)
    end
    wr(`SESUM_OFF_SRE, 32'h20);
    cond_q[0] <= 1'b1;
    settle();
    `CHK({srq, sb}, 9'h160)
    cmd(`SESUM_CMD_POLL);
    settle();
    `CHK({srq, sb}, 9'h060)
    cmd(`SESUM_CMD_CLS);
    settle();
    `CHK(sb, 8'h00)
    $display("test summary done");
    tick(0);
    `CHK(sb, 8'h10)
    tick(1);
    for (int k = 0; k < 3; k++) begin
      tick(2);
      `CHK(sb, 8'h04)
      cmd(clr[k]);
      settle();
      `CHK(sb, 8'h00)
    end
    tick(2);
    wr(at(`SESUM_OFF_ENA0, 1), 32'h55);
    cmd(`SESUM_CMD_SYSPRES);
    cmd(`SESUM_CMD_RST);
    settle();
    `CHK(sb, 8'h04)
    rd_chk(at(`SESUM_OFF_ENA0, 1), 32'h55);
    cmd(`SESUM_CMD_STPRES);
    rd_chk(at(`SESUM_OFF_ENA0, 1), 32'h0);
    rd_chk(`SESUM_OFF_ENA0, 32'h1);
    `CHK(sb, 8'h04)
    cmd(`SESUM_CMD_QCLR);
    $display("test queues done");
    foreach (ps[k]) begin
      parse(ps[k]);
      rd_chk(at(`SESUM_OFF_ENA0, 1), 32'h2C);
    end
    v = 16'($random(seed));
    parse($sformatf("%0d", v));
    rd_chk(at(`SESUM_OFF_ENA0, 1), {16'h0, v});
    parse($sformatf("#b%0b", ~v));
    rd_chk(at(`SESUM_OFF_ENA0, 1), {16'h0, ~v});
    parse("#q9");
    rd_chk(at(`SESUM_OFF_ENA0, 1), {16'h0, ~v});
    rd_chk(`SESUM_OFF_QSTAT, 32'h100);
    rd_chk(`SESUM_OFF_PSTAT, 32'h8000_0000);
    // Programming value aimed at the request enable instead of a set
    parse("#H7F", 4'hF);
    rd_chk(`SESUM_OFF_SRE, 32'h7F);
    $display("test parser done");
    end_sim();
  end
endmodule : tb_status_event_summary
bind sesum_top sesum_top_sva #(.NSETS(NSETS)) sva_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
  .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .cond_i(cond_i), .oq_push_i(oq_push_i), .oq_pop_i(oq_pop_i),
  .eq_push_i(eq_push_i), .eq_pop_i(eq_pop_i), .status_byte_o(status_byte_o), .srq_o(srq_o));
